// file: mcr_config_regs.sv
// Purpose: Config and status registers of a fault-tolerant memory controller
// Assumes: APB slave port, one clock, synchronous active-high reset
// Notes: Build options are parameters; absent fields read zero
`timescale 1ns/1ps
module mcr_config_regs #(
    parameter bit WSREG = 1'b0,
    parameter bit RMW = 1'b0,
    parameter bit EDACEN = 1'b0,
    parameter bit ERRCNT = 1'b0,
    parameter int CNTBITS = 1,
    parameter bit NARROW_PROM_OPTION = 1'b0,
    parameter logic [3:0] ROMWS = 4'h2,
    parameter logic [3:0] RAMWS = 4'h0,
    parameter logic [3:0] IOWS = 4'h2,
    parameter logic [3:0] ROMBANKSZ = 4'hf,
    parameter logic [3:0] ROMBANKSZDEF = 4'hf,
    parameter logic [3:0] RAMBANKSZ = 4'hf,
    // Arbitrary identity values
    parameter logic [7:0] VENDOR_ID = 8'h5a,
    parameter logic [11:0] DEVICE_ID = 12'h123
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // External pins
    input wire logic ext_ready_n_i,
    input wire logic ext_error_n_i,
    input wire logic [1:0] width_strap_i,
    input wire logic edac_strap_i,
    // Access sequencing
    input wire logic acc_start_i,
    input wire mcr_pkg::mcr_area_t acc_area_i,
    input wire logic acc_write_i,
    output logic acc_busy_o,
    output logic acc_done_o,
    output logic acc_error_o,
    // EDAC data path
    input wire logic corr_error_i,
    input wire logic read_cb_valid_i,
    input wire logic [7:0] read_cb_i,
    input wire logic [7:0] calc_cb_i,
    output logic [7:0] write_cb_o,
    input wire logic [31:0] prom_addr_i,
    output logic [31:0] checksum_addr_o,
    // Configuration view
    output mcr_pkg::mcr_cfg_t cfg_o,
    output logic narrow_prom_o,
    output logic [19:0] ident_o
);
    localparam bit EDAC_AREA_SIZE_OK = (ROMBANKSZ == 4'h0) && EDACEN && NARROW_PROM_OPTION;
    localparam bit CNT_OK = EDACEN && ERRCNT;
    localparam logic [7:0] CNT_MASK = 8'((9'h1 << CNTBITS) - 9'h1);

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction : hit

    // Pin synchronisers
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic ready_n_s;
    logic error_n_s;
    logic [1:0] strap_s;
    logic edac_s;

    always_ff @(posedge mclk_i) begin
        sync1_r <= {edac_strap_i, width_strap_i, ext_error_n_i, ext_ready_n_i};
        sync2_r <= sync1_r;
    end

    assign ready_n_s = sync2_r[0];
    assign error_n_s = sync2_r[1];
    assign strap_s = sync2_r[3:2];
    assign edac_s = sync2_r[4];

    // Register state
    logic io_rdy_en_r, io_rdy_en_nxt;
    logic bus_err_en_r, bus_err_en_nxt;
    logic [3:0] io_ws_r, io_ws_nxt;
    logic [3:0] prom_bsz_r, prom_bsz_nxt;
    logic [1:0] edac_area_size_r, edac_area_size_nxt;
    logic prom_we_r, prom_we_nxt;
    logic [1:0] prom_bw_r, prom_bw_nxt;
    logic [3:0] prom_ws_r, prom_ws_nxt;
    logic [3:0] sram_bsz_r, sram_bsz_nxt;
    logic rmw_en_r, rmw_en_nxt;
    logic [1:0] sram_ws_r, sram_ws_nxt;
    logic wb_r, wb_nxt;
    logic rb_r, rb_nxt;
    logic sram_edac_r, sram_edac_nxt;
    logic prom_edac_r, prom_edac_nxt;
    logic [7:0] tcb_r, tcb_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] cnt_base;

    logic wr_en;
    logic wr0;
    logic wr1;
    logic wr2;

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign wr0 = wr_en && hit(paddr_i, mcr_pkg::OFF_PROM_IO_CONFIG);
    assign wr1 = wr_en && hit(paddr_i, mcr_pkg::OFF_SRAM_CONFIG);
    assign wr2 = wr_en && hit(paddr_i, mcr_pkg::OFF_EDAC_CONFIG) && EDACEN;

    always_comb begin
        io_rdy_en_nxt = io_rdy_en_r;
        bus_err_en_nxt = bus_err_en_r;
        io_ws_nxt = io_ws_r;
        prom_bsz_nxt = prom_bsz_r;
        edac_area_size_nxt = edac_area_size_r;
        prom_we_nxt = prom_we_r;
        prom_bw_nxt = prom_bw_r;
        prom_ws_nxt = prom_ws_r;
        sram_bsz_nxt = sram_bsz_r;
        rmw_en_nxt = rmw_en_r;
        sram_ws_nxt = sram_ws_r;
        wb_nxt = wb_r;
        rb_nxt = rb_r;
        sram_edac_nxt = sram_edac_r;
        prom_edac_nxt = prom_edac_r;
        tcb_nxt = tcb_r;
        cnt_base = cnt_r;
        if (wr0) begin
            io_rdy_en_nxt = pwdata_i[mcr_pkg::IO_READY_EN_BIT];
            bus_err_en_nxt = pwdata_i[mcr_pkg::BUS_ERR_EN_BIT];
            if (WSREG) begin
                io_ws_nxt = pwdata_i[mcr_pkg::IO_WS_LSB +: 4];
                prom_ws_nxt = pwdata_i[mcr_pkg::PROM_WS_LSB +: 4];
            end
            if (ROMBANKSZ == 4'h0) begin
                prom_bsz_nxt = pwdata_i[mcr_pkg::PROM_BSZ_LSB +: 4];
            end
            if (EDAC_AREA_SIZE_OK) begin
                edac_area_size_nxt = pwdata_i[mcr_pkg::EDAC_AREA_LSB +: 2];
            end
            prom_we_nxt = pwdata_i[mcr_pkg::PROM_WE_BIT];
            prom_bw_nxt = pwdata_i[mcr_pkg::PROM_BW_LSB +: 2];
        end
        if (wr1) begin
            if (RAMBANKSZ == 4'h0) begin
                sram_bsz_nxt = pwdata_i[mcr_pkg::SRAM_BSZ_LSB +: 4];
            end
            if (RMW) begin
                rmw_en_nxt = pwdata_i[mcr_pkg::RMW_EN_BIT];
            end
            if (WSREG) begin
                sram_ws_nxt = pwdata_i[mcr_pkg::SRAM_WS_LSB +: 2];
            end
        end
        if (wr2) begin
            wb_nxt = pwdata_i[mcr_pkg::WB_BIT];
            rb_nxt = pwdata_i[mcr_pkg::RB_BIT];
            sram_edac_nxt = pwdata_i[mcr_pkg::SRAM_EDAC_BIT];
            prom_edac_nxt = pwdata_i[mcr_pkg::PROM_EDAC_BIT];
            tcb_nxt = pwdata_i[mcr_pkg::TCB_LSB +: 8];
            cnt_base = cnt_r & ~pwdata_i[mcr_pkg::ERR_CNT_LSB +: 8];
        end
        // Capture from memory wins over a software write
        if (EDACEN && rb_r && read_cb_valid_i) begin
            tcb_nxt = read_cb_i;
        end
        // Increment on top of a clear so no event is lost
        if (CNT_OK && corr_error_i && (cnt_base != CNT_MASK)) begin
            cnt_nxt = (cnt_base + 8'h01) & CNT_MASK;
        end else begin
            cnt_nxt = cnt_base & CNT_MASK;
        end
        if (!CNT_OK) begin
            cnt_nxt = mcr_pkg::ERR_CNT_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            io_rdy_en_r <= 1'b0;
            bus_err_en_r <= 1'b0;
            io_ws_r <= IOWS;
            prom_bsz_r <= ROMBANKSZDEF;
            edac_area_size_r <= 2'h0;
            prom_we_r <= 1'b0;
            prom_bw_r <= strap_s;
            prom_ws_r <= mcr_pkg::PROM_WS_RST;
            sram_bsz_r <= 4'h0;
            rmw_en_r <= 1'b0;
            sram_ws_r <= RAMWS[1:0];
            wb_r <= 1'b0;
            rb_r <= 1'b0;
            sram_edac_r <= 1'b0;
            prom_edac_r <= edac_s && EDACEN;
            tcb_r <= mcr_pkg::TCB_RST;
            cnt_r <= mcr_pkg::ERR_CNT_RST;
        end else begin
            io_rdy_en_r <= io_rdy_en_nxt;
            bus_err_en_r <= bus_err_en_nxt;
            io_ws_r <= io_ws_nxt;
            prom_bsz_r <= prom_bsz_nxt;
            edac_area_size_r <= edac_area_size_nxt;
            prom_we_r <= prom_we_nxt;
            prom_bw_r <= prom_bw_nxt;
            prom_ws_r <= prom_ws_nxt;
            sram_bsz_r <= sram_bsz_nxt;
            rmw_en_r <= rmw_en_nxt;
            sram_ws_r <= sram_ws_nxt;
            wb_r <= wb_nxt;
            rb_r <= rb_nxt;
            sram_edac_r <= sram_edac_nxt;
            prom_edac_r <= prom_edac_nxt;
            tcb_r <= tcb_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Effective configuration
    always_comb begin
        cfg_o = '0;
        cfg_o.io_ready_enable = io_rdy_en_r;
        cfg_o.bus_error_enable = bus_err_en_r;
        cfg_o.io_waitstates = WSREG ? io_ws_r : IOWS;
        cfg_o.prom_bank_size = (ROMBANKSZ == 4'h0) ? prom_bsz_r : ROMBANKSZ;
        cfg_o.edac_area_size = EDAC_AREA_SIZE_OK ? edac_area_size_r : 2'h0;
        cfg_o.prom_write_enable = prom_we_r;
        cfg_o.prom_bus_width = prom_bw_r;
        cfg_o.prom_waitstates = WSREG ? prom_ws_r : ROMWS;
        cfg_o.sram_bank_size = (RAMBANKSZ == 4'h0) ? sram_bsz_r : RAMBANKSZ;
        cfg_o.rmw_enable = RMW && rmw_en_r;
        cfg_o.sram_waitstates = WSREG ? sram_ws_r : RAMWS[1:0];
        cfg_o.checkbit_write_bypass = EDACEN && wb_r;
        cfg_o.checkbit_read_bypass = EDACEN && rb_r;
        cfg_o.sram_edac_enable = EDACEN && sram_edac_r;
        cfg_o.prom_edac_enable = EDACEN && prom_edac_r;
        cfg_o.test_checkbits = EDACEN ? tcb_r : 8'h00;
        cfg_o.correctable_error_count = cnt_r;
    end

    // 8-bit PROM mode only for the narrow code
    assign narrow_prom_o = NARROW_PROM_OPTION && (prom_bw_r == mcr_pkg::PROM_BW_NARROW);
    assign ident_o = {VENDOR_ID, DEVICE_ID};

    // APB read data
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        pslverr_o = 1'b0;
        if (hit(paddr_i, mcr_pkg::OFF_PROM_IO_CONFIG)) begin
            rd_word[mcr_pkg::IO_READY_EN_BIT] = cfg_o.io_ready_enable;
            rd_word[mcr_pkg::BUS_ERR_EN_BIT] = cfg_o.bus_error_enable;
            rd_word[mcr_pkg::IO_WS_LSB +: 4] = WSREG ? io_ws_r : 4'h0;
            rd_word[mcr_pkg::PROM_BSZ_LSB +: 4] = cfg_o.prom_bank_size;
            rd_word[mcr_pkg::EDAC_AREA_LSB +: 2] = cfg_o.edac_area_size;
            rd_word[mcr_pkg::PROM_WE_BIT] = cfg_o.prom_write_enable;
            rd_word[mcr_pkg::PROM_BW_LSB +: 2] = cfg_o.prom_bus_width;
            rd_word[mcr_pkg::PROM_WS_LSB +: 4] = WSREG ? prom_ws_r : 4'h0;
        end else if (hit(paddr_i, mcr_pkg::OFF_SRAM_CONFIG)) begin
            rd_word[mcr_pkg::SRAM_BSZ_LSB +: 4] = cfg_o.sram_bank_size;
            rd_word[mcr_pkg::RMW_EN_BIT] = cfg_o.rmw_enable;
            rd_word[mcr_pkg::SRAM_WS_LSB +: 2] = WSREG ? sram_ws_r : 2'h0;
        end else if (hit(paddr_i, mcr_pkg::OFF_EDAC_CONFIG)) begin
            rd_word[mcr_pkg::ERR_CNT_LSB +: 8] = cnt_r;
            rd_word[mcr_pkg::WB_BIT] = cfg_o.checkbit_write_bypass;
            rd_word[mcr_pkg::RB_BIT] = cfg_o.checkbit_read_bypass;
            rd_word[mcr_pkg::SRAM_EDAC_BIT] = cfg_o.sram_edac_enable;
            rd_word[mcr_pkg::PROM_EDAC_BIT] = cfg_o.prom_edac_enable;
            rd_word[mcr_pkg::TCB_LSB +: 8] = cfg_o.test_checkbits;
        end else begin
            pslverr_o = psel_i && penable_i;
        end
    end

    assign prdata_o = rd_word;
    assign pready_o = 1'b1;

    // Access timing and error answers
    logic [3:0] acc_ws;
    logic timer_start;
    logic timer_done;
    logic refuse_r, refuse_nxt;
    logic acc_io_r, acc_io_nxt;

    always_comb begin
        case (acc_area_i)
            mcr_pkg::MCR_AREA_PROM: acc_ws = cfg_o.prom_waitstates;
            mcr_pkg::MCR_AREA_SRAM: acc_ws = {2'h0, cfg_o.sram_waitstates};
            mcr_pkg::MCR_AREA_IO: acc_ws = cfg_o.io_waitstates;
            default: acc_ws = cfg_o.io_waitstates;
        endcase
    end

    always_comb begin
        refuse_nxt = acc_start_i && !acc_busy_o && acc_write_i && !prom_we_r
            && (acc_area_i == mcr_pkg::MCR_AREA_PROM);
        acc_io_nxt = acc_io_r;
        if (acc_start_i && !acc_busy_o) begin
            acc_io_nxt = (acc_area_i == mcr_pkg::MCR_AREA_IO);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            refuse_r <= 1'b0;
            acc_io_r <= 1'b0;
        end else begin
            refuse_r <= refuse_nxt;
            acc_io_r <= acc_io_nxt;
        end
    end

    assign timer_start = acc_start_i && !refuse_nxt && !refuse_r;

    mcr_wait_timer u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(timer_start),
        .ws_i(acc_ws),
        .stretch_i(io_rdy_en_r && (acc_area_i == mcr_pkg::MCR_AREA_IO)),
        .ready_n_i(ready_n_s),
        .busy_o(acc_busy_o),
        .done_o(timer_done)
    );

    assign acc_done_o = timer_done || refuse_r;
    // Error pin sampled with the last data cycle
    assign acc_error_o = refuse_r || (timer_done && bus_err_en_r && !error_n_s);

    // Checkbit and checksum address outputs
    logic [7:0] write_cb_r, write_cb_nxt;
    logic [31:0] cks_addr_r, cks_addr_nxt;
    logic [5:0] area_exp;
    logic [31:0] area_bytes;

    always_comb begin
        write_cb_nxt = cfg_o.checkbit_write_bypass ? tcb_r : calc_cb_i;
        area_exp = mcr_pkg::BANK_BASE_EXP + {2'h0, cfg_o.prom_bank_size}
            + {4'h0, cfg_o.edac_area_size};
        area_bytes = 32'h1 << area_exp;
        cks_addr_nxt = (area_bytes >> 1) + (area_bytes >> 2) + (prom_addr_i >> 2);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            write_cb_r <= 8'h00;
            cks_addr_r <= 32'h0000_0000;
        end else begin
            write_cb_r <= write_cb_nxt;
            cks_addr_r <= cks_addr_nxt;
        end
    end

    assign write_cb_o = write_cb_r;
    assign checksum_addr_o = cks_addr_r;

endmodule : mcr_config_regs

// file: mcr_pkg.sv
// Purpose: Constants and types of the config bank
// Assumes: 32-bit register words on the documented register port
// Notes: Field positions and the PROM waitstate, counter and test checkbit reset values live here; widths and other resets are in mcr_config_regs
package mcr_pkg;

    // Register offsets
    localparam logic [11:0] OFF_PROM_IO_CONFIG = 12'h000;
    localparam logic [11:0] OFF_SRAM_CONFIG = 12'h004;
    localparam logic [11:0] OFF_EDAC_CONFIG = 12'h008;

    // First register fields
    localparam int IO_READY_EN_BIT = 26;
    localparam int BUS_ERR_EN_BIT = 25;
    localparam int IO_WS_LSB = 20;
    localparam int PROM_BSZ_LSB = 14;
    localparam int EDAC_AREA_LSB = 12;
    localparam int PROM_WE_BIT = 11;
    localparam int PROM_BW_LSB = 8;
    localparam int PROM_WS_LSB = 0;

    // Second register fields
    localparam int SRAM_BSZ_LSB = 9;
    localparam int RMW_EN_BIT = 6;
    localparam int SRAM_WS_LSB = 0;

    // Third register fields
    localparam int ERR_CNT_LSB = 12;
    localparam int WB_BIT = 11;
    localparam int RB_BIT = 10;
    localparam int SRAM_EDAC_BIT = 9;
    localparam int PROM_EDAC_BIT = 8;
    localparam int TCB_LSB = 0;

    // Reset values and bus width codes
    localparam logic [3:0] PROM_WS_RST = 4'hf;
    localparam logic [1:0] PROM_BW_NARROW = 2'h0;
    localparam logic [1:0] PROM_BW_WIDE = 2'h2;
    localparam logic [7:0] ERR_CNT_RST = 8'h00;
    localparam logic [7:0] TCB_RST = 8'h00;

    // EDAC area arithmetic: smallest bank is 8 kB
    localparam logic [5:0] BANK_BASE_EXP = 6'h0d;

    typedef enum logic [1:0] {
        MCR_AREA_PROM,
        MCR_AREA_SRAM,
        MCR_AREA_IO
    } mcr_area_t;

    typedef struct packed {
        logic io_ready_enable;
        logic bus_error_enable;
        logic [3:0] io_waitstates;
        logic [3:0] prom_bank_size;
        logic [1:0] edac_area_size;
        logic prom_write_enable;
        logic [1:0] prom_bus_width;
        logic [3:0] prom_waitstates;
        logic [3:0] sram_bank_size;
        logic rmw_enable;
        logic [1:0] sram_waitstates;
        logic checkbit_write_bypass;
        logic checkbit_read_bypass;
        logic sram_edac_enable;
        logic prom_edac_enable;
        logic [7:0] test_checkbits;
        logic [7:0] correctable_error_count;
    } mcr_cfg_t;

endpackage : mcr_pkg

// file: mcr_wait_timer.sv
// Purpose: Waitstate and bus-ready stretch timer for one memory access
// Assumes: ready_n_i is already synchronised
// Notes: Done comes ws_i+1 cycles after start unless stretched
`timescale 1ns/1ps
module mcr_wait_timer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Access control
    input wire logic start_i,
    input wire logic [3:0] ws_i,
    input wire logic stretch_i,
    input wire logic ready_n_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    typedef enum logic [1:0] {
        WT_IDLE,
        WT_COUNT,
        WT_STRETCH
    } mcr_wt_state_t;

    mcr_wt_state_t state_r;
    mcr_wt_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic stretch_r;
    logic stretch_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        stretch_nxt = stretch_r;
        done_o = 1'b0;
        case (state_r)
            WT_IDLE: begin
                if (start_i) begin
                    state_nxt = WT_COUNT;
                    cnt_nxt = ws_i;
                    stretch_nxt = stretch_i;
                end
            end
            WT_COUNT: begin
                // One extra data cycle per waitstate
                if (cnt_r != 4'h0) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else if (stretch_r && ready_n_i) begin
                    state_nxt = WT_STRETCH;
                end else begin
                    done_o = 1'b1;
                    state_nxt = WT_IDLE;
                end
            end
            WT_STRETCH: begin
                // Held until the ready pin goes low
                if (!ready_n_i) begin
                    done_o = 1'b1;
                    state_nxt = WT_IDLE;
                end
            end
            default: begin
                state_nxt = WT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= WT_IDLE;
            cnt_r <= 4'h0;
            stretch_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            stretch_r <= stretch_nxt;
        end
    end

    assign busy_o = (state_r != WT_IDLE);

endmodule : mcr_wait_timer

// file: mcr_config_regs_sva.sv
// Purpose: Port assertions for the config bank
// Assumes: Bound to mcr_config_regs, synchronous active-high reset
// Notes: Port, timer, counter, checkbits
`timescale 1ns/1ps
module mcr_config_regs_sva #(
    parameter int CNTBITS = 1,
    parameter bit NARROW_PROM_OPTION = 1'b0
) (
    // Clock, reset and register port
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Access timer
    input wire logic acc_start_i,
    input wire mcr_pkg::mcr_area_t acc_area_i,
    input wire logic acc_write_i,
    input wire logic acc_busy_o,
    input wire logic acc_done_o,
    input wire logic acc_error_o,
    // Error detection path and configuration view
    input wire logic corr_error_i,
    input wire logic read_cb_valid_i,
    input wire logic [7:0] read_cb_i,
    input wire logic [7:0] calc_cb_i,
    input wire logic [7:0] write_cb_o,
    input wire mcr_pkg::mcr_cfg_t cfg_o,
    input wire logic narrow_prom_o,
    input wire logic [19:0] ident_o
);
    logic mapped;
    logic reg3_wr;
    logic start_ok;
    logic [7:0] cnt;
    logic [7:0] cnt_max;
    assign mapped = paddr_i inside {12'h000, 12'h004, 12'h008};
    assign reg3_wr = psel_i && penable_i && pwrite_i && (paddr_i == 12'h008);
    assign start_ok = acc_start_i && !acc_busy_o;
    assign cnt = cfg_o.correctable_error_count;
    assign cnt_max = 8'((1 << CNTBITS) - 1);
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ready_always_a: assert property (pready_o)
        else $error("ready low");
    slverr_map_a: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
        else $error("slave error wrong");
    wr_bypass_a: assert property (!$past(rst_i) |-> write_cb_o ==
        ($past(cfg_o.checkbit_write_bypass) ? $past(cfg_o.test_checkbits) : $past(calc_cb_i)))
        else $error("write checkbits wrong");
    rd_capture_a: assert property (cfg_o.checkbit_read_bypass && read_cb_valid_i
        |=> cfg_o.test_checkbits == $past(read_cb_i)) else $error("read checkbits lost");
    cnt_step_a: assert property (corr_error_i && !reg3_wr
        |=> cnt == (($past(cnt) == cnt_max) ? cnt_max : $past(cnt) + 8'h01))
        else $error("counter step wrong");
    cnt_clear_a: assert property (reg3_wr && !corr_error_i
        |=> cnt == ($past(cnt) & ~$past(pwdata_i[19:12]))) else $error("counter clear wrong");
    prom_refuse_a: assert property (start_ok && acc_area_i == mcr_pkg::MCR_AREA_PROM
        && acc_write_i && !cfg_o.prom_write_enable |=> acc_done_o && acc_error_o)
        else $error("prom write not refused");
    sram_wait_a: assert property (start_ok && acc_area_i == mcr_pkg::MCR_AREA_SRAM
        && cfg_o.sram_waitstates == 2'h1 |=> !acc_done_o ##1 acc_done_o ##1 !acc_busy_o)
        else $error("sram wait timing wrong");
    no_error_a: assert property (acc_done_o && !cfg_o.bus_error_enable
        && cfg_o.prom_write_enable |-> !acc_error_o) else $error("stray access error");
    narrow_a: assert property (narrow_prom_o == (NARROW_PROM_OPTION && cfg_o.prom_bus_width == 2'h0))
        else $error("narrow mode wrong");
    ident_a: assert property ($stable(ident_o))
        else $error("identity changed");
    cover property (start_ok && acc_area_i == mcr_pkg::MCR_AREA_IO && cfg_o.io_ready_enable);
    cover property (cnt == cnt_max && corr_error_i);
    cover property (reg3_wr && cfg_o.checkbit_read_bypass);
endmodule : mcr_config_regs_sva

// file: mcr_apb_master.sv
// Purpose: APB master model for the register port
// Assumes: Slave answers with ready sampled at a rising edge
// Notes: Address and data are inverted on release
`timescale 1ns/1ps
module mcr_apb_master (
    // Clock
    input wire logic mclk_i,
    // APB master
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [11:0] paddr_o = 12'h000,
    output logic [31:0] pwdata_o = 32'h0,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge mclk_i);
        #1;
        psel_o = 1'b1;
        pwrite_o = wr;
        paddr_o = a;
        pwdata_o = d;
        @(posedge mclk_i);
        #1;
        penable_o = 1'b1;
        @(posedge mclk_i);
        while (pready_i !== 1'b1) @(posedge mclk_i);
        q = prdata_i;
        e = pslverr_i;
        #1;
        psel_o = 1'b0;
        penable_o = 1'b0;
        paddr_o = ~paddr_o;
        pwdata_o = ~pwdata_o;
    endtask : xfer
endmodule : mcr_apb_master

// file: mcr_config_regs_test.sv
// Purpose: Self-checking bench for the config bank
// Assumes: Partner APB master drives the register port
// Notes: Narrow PROM, EDAC, counter, programmable waits
`timescale 1ns/1ps
module mcr_config_regs_test;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic ext_ready_n_i = 1'b0, ext_error_n_i = 1'b1, edac_strap_i = 1'b1;
    logic acc_start_i = 1'b0, acc_write_i = 1'b0, corr_error_i = 1'b0, read_cb_valid_i = 1'b0;
    logic [1:0] width_strap_i = 2'h2;
    mcr_pkg::mcr_area_t acc_area_i = mcr_pkg::MCR_AREA_PROM;
    logic [7:0] read_cb_i = 8'h00, calc_cb_i = 8'h3c, write_cb_o;
    logic [31:0] prom_addr_i = 32'h4, checksum_addr_o, prdata_o, pwdata_i;
    logic [11:0] paddr_i;
    logic acc_busy_o, acc_done_o, acc_error_o, narrow_prom_o;
    logic [19:0] ident_o;
    mcr_pkg::mcr_cfg_t cfg_o;
    int n_errors = 0, comparisons = 0, cycles = 0;
    mcr_config_regs #(.WSREG(1'b1), .EDACEN(1'b1), .ERRCNT(1'b1), .NARROW_PROM_OPTION(1'b1),
        .ROMBANKSZ(4'h0)) u_dut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext_ready_n_i, .ext_error_n_i,
        .width_strap_i, .edac_strap_i, .acc_start_i, .acc_area_i, .acc_write_i, .acc_busy_o,
        .acc_done_o, .acc_error_o, .corr_error_i, .read_cb_valid_i, .read_cb_i, .calc_cb_i,
        .write_cb_o, .prom_addr_i, .checksum_addr_o, .cfg_o, .narrow_prom_o, .ident_o);
    mcr_apb_master u_apb (.mclk_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
        .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
        .pslverr_i(pslverr_o));
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_apb.xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        u_apb.xfer(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask : rd
    task tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task acc(input mcr_pkg::mcr_area_t ar, input logic w, input logic [31:0] n_exp,
             input logic e_exp);
        logic [31:0] n;
        tick(1);
        acc_start_i = 1'b1;
        acc_area_i = ar;
        acc_write_i = w;
        tick(1);
        acc_start_i = 1'b0;
        n = 32'h1;
        while (acc_done_o !== 1'b1 && n < 32'h28) begin
            tick(1);
            n++;
        end
        chk("access error", {31'h0, e_exp}, {31'h0, acc_error_o});
        if (n_exp != 32'h0) chk("access cycles", n_exp, n);
        else chk("stretched", 32'h1, {31'h0, n > 32'h6 && n < 32'hb});
    endtask : acc
    task t_regs;
        logic [31:0] q;
        logic e;
        rd("prom_io_config", 12'h000, 32'h0023c20f);
        rd("sram_config", 12'h004, 32'h00001e00);
        rd("edac_config", 12'h008, 32'h00000100);
        wr(12'h000, 32'hffffffff);
        rd("prom_io_config", 12'h000, 32'h06f3fb0f);
        wr(12'h004, 32'hffffffff);
        rd("sram_config", 12'h004, 32'h00001e03);
        wr(12'h008, 32'hffffffff);
        rd("edac_config", 12'h008, 32'h00000fff);
        chk("write_cb", 32'hff, {24'h0, write_cb_o});
        u_apb.xfer(1'b0, 12'h00c, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask : t_regs
    task t_edac;
        wr(12'h008, 32'h000008a5);
        tick(1);
        chk("write_cb", 32'ha5, {24'h0, write_cb_o});
        wr(12'h008, 32'h00000400);
        tick(1);
        chk("write_cb", 32'h3c, {24'h0, write_cb_o});
        read_cb_i = 8'h96;
        read_cb_valid_i = 1'b1;
        tick(1);
        read_cb_valid_i = 1'b0;
        rd("edac_config", 12'h008, 32'h00000496);
        corr_error_i = 1'b1;
        tick(5);
        corr_error_i = 1'b0;
        rd("edac_config", 12'h008, 32'h00001496);
        wr(12'h008, 32'h00001496);
        rd("edac_config", 12'h008, 32'h00000496);
    endtask : t_edac
    task t_prom;
        wr(12'h000, 32'h00029000);
        tick(1);
        chk("checksum", 32'h00c00001, checksum_addr_o);
        chk("narrow", 32'h1, {31'h0, narrow_prom_o});
        wr(12'h000, 32'h00000000);
        acc(mcr_pkg::MCR_AREA_PROM, 1'b1, 32'h1, 1'b1);
        wr(12'h000, 32'h00000802);
        acc(mcr_pkg::MCR_AREA_PROM, 1'b1, 32'h3, 1'b0);
        wr(12'h004, 32'h00000001);
        acc(mcr_pkg::MCR_AREA_SRAM, 1'b0, 32'h2, 1'b0);
        ext_error_n_i = 1'b0;
        wr(12'h000, 32'h02100800);
        acc(mcr_pkg::MCR_AREA_IO, 1'b0, 32'h2, 1'b1);
        ext_error_n_i = 1'b1;
        wr(12'h000, 32'h04100000);
        ext_ready_n_i = 1'b1;
        fork
            acc(mcr_pkg::MCR_AREA_IO, 1'b1, 32'h0, 1'b0);
            begin
                tick(7);
                ext_ready_n_i = 1'b0;
            end
        join
    endtask : t_prom
    task test_done;
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        tick(16);
        rst_i = 1'b0;
        t_regs();
        t_edac();
        t_prom();
        test_done();
    end
endmodule : mcr_config_regs_test
bind mcr_config_regs mcr_config_regs_sva #(.CNTBITS(CNTBITS), .NARROW_PROM_OPTION(NARROW_PROM_OPTION)) u_sva (
    .mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
    .pslverr_o, .acc_start_i, .acc_area_i, .acc_write_i, .acc_busy_o, .acc_done_o,
    .acc_error_o, .corr_error_i, .read_cb_valid_i, .read_cb_i, .calc_cb_i, .write_cb_o,
    .cfg_o, .narrow_prom_o, .ident_o);
